// ---- core/ocd_pkg.sv ----
package ocd_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Default widths
  localparam int N_SRC_DEF  = 2;
  localparam int N_CH_DEF   = 4;
  localparam int N_BUS_DEF  = 8;
  localparam int DIV_W      = 8;
  localparam int BUS_DATA_W = 32;

  // Edges of a slow clock to wait for; two edges span one to two periods
  localparam logic [1:0] SETTLE_EDGES = 2'h2;

  // Division after reset: undivided main clock
  localparam logic [7:0] DIV_RESET = 8'h01;
  localparam logic [7:0] DIV_ONE   = 8'h01;
  localparam logic [7:0] DIV_ZERO  = 8'h00;

  // Bus clock mask positions that come out of reset disabled
  localparam int COMPARATOR_BUS_BIT = 0;
  localparam int CONVERTER0_BUS_BIT = 1;

  typedef enum logic [2:0] {
    SRC_OFF       = 3'b000,
    SRC_WAIT_RDY  = 3'b001,
    SRC_START_SRC = 3'b010,
    SRC_START_DIV = 3'b011,
    SRC_RUN       = 3'b100,
    SRC_STOP_DIV  = 3'b101,
    SRC_STOP_SRC  = 3'b110
  } ocd_src_state_t;

  typedef struct packed {
    ocd_src_state_t st;
    logic [1:0]     edges;
    logic           src_en;
    logic           avail;
  } ocd_src_reg_t;

  typedef struct packed {
    logic [7:0] div_reg;
    logic [7:0] div_act;
    logic [7:0] pend;
    logic       pending;
    logic [7:0] cnt;
    logic       cpu_en;
    logic       ready;
    logic       irq;
    logic       viol;
  } ocd_div_t;

  // Zero would divide by nothing; every other value is usable
  function automatic logic ocd_div_allowed(input logic [7:0] v);
    ocd_div_allowed = (v != DIV_ZERO);
  endfunction

endpackage

// ---- core/ocd_src_ctl.sv ----
`timescale 1ns/1ps
module ocd_src_ctl
  import ocd_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_req_any,
  input  wire logic i_on_demand,
  input  wire logic i_ready,
  input  wire logic i_src_tick,
  input  wire logic i_div_tick,
  output logic      o_src_en,
  output logic      o_avail
);

  ocd_src_reg_t r;
  ocd_src_reg_t next_r;
  logic         need;

  assign need = i_req_any | ~i_on_demand;

  always_comb begin
    next_r = r;
    if (i_srst) begin
      next_r = '{st: SRC_OFF, edges: 2'h0, src_en: 1'b0, avail: 1'b0};
    end else if (i_ce) begin
      case (r.st)
        SRC_OFF: begin
          if (need) begin
            next_r.src_en = 1'b1;
            next_r.st     = SRC_WAIT_RDY;
          end
        end
        SRC_WAIT_RDY: begin
          next_r.edges = 2'h0;
          if (i_ready) begin
            next_r.st = SRC_START_SRC;
          end
        end
        SRC_START_SRC: begin
          if (i_src_tick) begin
            next_r.edges = r.edges + 2'h1;
            if (r.edges + 2'h1 == SETTLE_EDGES) begin
              next_r.edges = 2'h0;
              next_r.st    = SRC_START_DIV;
            end
          end
        end
        SRC_START_DIV: begin
          if (i_div_tick) begin
            next_r.edges = r.edges + 2'h1;
            if (r.edges + 2'h1 == SETTLE_EDGES) begin
              next_r.edges = 2'h0;
              next_r.avail = 1'b1;
              next_r.st    = SRC_RUN;
            end
          end
        end
        SRC_RUN: begin
          if (!need) begin
            next_r.avail = 1'b0;
            next_r.edges = 2'h0;
            next_r.st    = SRC_STOP_DIV;
          end
        end
        SRC_STOP_DIV, SRC_STOP_SRC: begin
          // Source still runs, so a returning request skips startup
          if (need) begin
            next_r.edges = 2'h0;
            next_r.st    = SRC_START_SRC;
          end else if ((r.st == SRC_STOP_DIV) ? i_div_tick : i_src_tick) begin
            next_r.edges = r.edges + 2'h1;
            if (r.edges + 2'h1 == SETTLE_EDGES) begin
              next_r.edges = 2'h0;
              if (r.st == SRC_STOP_DIV) begin
                next_r.st = SRC_STOP_SRC;
              end else begin
                next_r.src_en = 1'b0;
                next_r.st     = SRC_OFF;
              end
            end
          end
        end
        default: begin
          next_r = '{st: SRC_OFF, edges: 2'h0, src_en: 1'b0, avail: 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    r <= next_r;
  end

  assign o_src_en = r.src_en;
  assign o_avail  = r.avail;

  avail_needs_src_a: assert property (@(posedge i_clk) disable iff (i_srst)
    r.avail |-> r.src_en)
    else $error("clock granted while source stopped");

  always_on_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (r.st == SRC_RUN) && !i_on_demand |=> (r.st == SRC_RUN) && r.avail)
    else $error("free-running source left run state");

  stop_no_grant_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (r.st == SRC_RUN) && i_ce && !need |=> !r.avail ##0 r.src_en)
    else $error("stop did not withdraw clock or stopped too early");

  ready_starts_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (r.st == SRC_WAIT_RDY) && i_ce && i_ready |=> (r.st == SRC_START_SRC) && !r.avail)
    else $error("ready source did not begin settle count");

endmodule

// ---- core/ocd_sync.sv ----
`timescale 1ns/1ps
module ocd_sync
  import ocd_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ocd_sync_t;

  ocd_sync_t r;
  ocd_sync_t next_r;

  always_comb begin
    next_r = r;
    if (i_srst) begin
      next_r = '0;
    end else if (i_ce) begin
      next_r.meta = i_async;
      next_r.sync = r.meta;
    end
  end

  always_ff @(posedge i_clk) begin
    r <= next_r;
  end

  assign o_sync = r.sync;

endmodule

// ---- core/ocd_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Run a request-driven source only while a request needs it; stop when none remain.
// - Pass a request only if peripheral, channel and generator are all enabled.
// - Grant clock after startup plus one-to-two source and divided periods.
// - Stop source one-to-two divided plus one-to-two source periods after last drop.
// - Each source has its own request-driven run bit; cleared means always running.
// - In standby, keep serving requests from run-in-standby modules.
// - CPU-domain clocks come from the main clock through an 8-bit prescaler.
// - After reset the synchronous clocks run undivided.
// - CPU clock rate equals main clock rate over the last applied allowed division value.
// - Forbidden division is stored but not used, and a violation is flagged.
// - New division applies to all synchronous clocks at one instant.
// - Clock ready flag reads zero from an allowed division write until it takes effect.
// - With interrupt enabled, raise clock-ready interrupt when setting takes effect.
// - A rewrite while ready is zero reports a violation.
// - Each peripheral has a mask bit gating its bus clock: 0 stops, 1 runs.
// - Comparator and converter 0 bus clocks start disabled after reset.
// - Masked peripheral reads return zeros and writes are dropped.
module ocd_top
  import ocd_pkg::*;
#(
  parameter int N_SRC = N_SRC_DEF,
  parameter int N_CH  = N_CH_DEF,
  parameter int N_BUS = N_BUS_DEF
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_SRST,
  input  wire logic                     I_CE,
  input  wire logic [N_SRC-1:0]         I_SRC_READY,
  input  wire logic [N_SRC-1:0]         I_SRC_TICK,
  input  wire logic [N_SRC-1:0]         I_DIV_TICK,
  input  wire logic [N_SRC-1:0]         I_REQUEST_DRIVEN_RUN,
  input  wire logic [N_SRC-1:0]         I_GEN_EN,
  input  wire logic [N_SRC*N_CH-1:0]    I_CHAN_EN,
  input  wire logic [N_SRC*N_CH-1:0]    I_PERIPH_EN,
  input  wire logic [N_SRC*N_CH-1:0]    I_PERIPH_REQ,
  input  wire logic [N_SRC*N_CH-1:0]    I_RUN_IN_STANDBY,
  input  wire logic                     I_STANDBY,
  input  wire logic                     I_DIV_WR,
  input  wire logic [DIV_W-1:0]         I_DIV_DATA,
  input  wire logic                     I_CLOCK_READY_FLAG_INT_EN,
  input  wire logic                     I_MASK_WR,
  input  wire logic [N_BUS-1:0]         I_MASK_DATA,
  input  wire logic [$clog2(N_BUS)-1:0] I_BUS_SEL,
  input  wire logic                     I_BUS_WR,
  input  wire logic [BUS_DATA_W-1:0]    I_BUS_RDATA,
  output logic      [N_SRC-1:0]         O_SRC_EN,
  output logic      [N_SRC-1:0]         O_SRC_AVAIL,
  output logic      [N_SRC*N_CH-1:0]    O_CLK_GRANT,
  output logic                          O_CPU_CLK_EN,
  output logic      [DIV_W-1:0]         O_CPU_DIVISION_REGISTER,
  output logic                          O_CLOCK_READY_FLAG,
  output logic                          O_CLOCK_READY_FLAG_IRQ,
  output logic                          O_PROTECT_VIOLATION,
  output logic      [N_BUS-1:0]         O_BUS_CLK_EN,
  output logic      [N_BUS-1:0]         O_BUS_MASK,
  output logic                          O_BUS_WR,
  output logic      [BUS_DATA_W-1:0]    O_BUS_RDATA
);

  localparam int NR = N_SRC * N_CH;

  typedef struct packed {
    logic [N_SRC-1:0]      req_any;
    logic [NR-1:0]         grant;
    ocd_div_t              d;
    logic [N_BUS-1:0]      mask;
    logic [N_BUS-1:0]      bus_clk;
    logic                  bus_wr;
    logic [BUS_DATA_W-1:0] rdata;
  } ocd_top_t;

  ocd_top_t         r;
  ocd_top_t         next_r;
  logic [NR-1:0]    eff_req;
  logic [N_SRC-1:0] ready_sync;
  logic [N_SRC-1:0] src_en;
  logic [N_SRC-1:0] avail;
  logic             wrap;

  // Oscillator ready comes from the analog side
  ocd_sync #(
    .W (N_SRC)
  ) u_ready_sync (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_ce    (I_CE),
    .i_async (I_SRC_READY),
    .o_sync  (ready_sync)
  );

  // Request qualification per channel
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_req
      assign eff_req[g] = I_PERIPH_REQ[g] & I_PERIPH_EN[g] & I_CHAN_EN[g]
                        & I_GEN_EN[g / N_CH]
                        & (~I_STANDBY | I_RUN_IN_STANDBY[g]);
    end
    for (g = 0; g < N_SRC; g++) begin : g_src
      ocd_src_ctl u_src (
        .i_clk       (I_CLK),
        .i_srst      (I_SRST),
        .i_ce        (I_CE),
        .i_req_any   (r.req_any[g]),
        .i_on_demand (I_REQUEST_DRIVEN_RUN[g]),
        .i_ready     (ready_sync[g]),
        .i_src_tick  (I_SRC_TICK[g]),
        .i_div_tick  (I_DIV_TICK[g]),
        .o_src_en    (src_en[g]),
        .o_avail     (avail[g])
      );
    end
  endgenerate

  // Last main-clock cycle of the current divided period
  assign wrap = (r.d.cnt == r.d.div_act - DIV_ONE);

  always_comb begin
    next_r = r;
    if (I_SRST) begin
      next_r           = '0;
      next_r.d.div_reg = DIV_RESET;
      next_r.d.div_act = DIV_RESET;
      next_r.d.pend    = DIV_RESET;
      next_r.d.ready   = 1'b1;
      next_r.mask      = '1;
      next_r.mask[COMPARATOR_BUS_BIT] = 1'b0;
      next_r.mask[CONVERTER0_BUS_BIT] = 1'b0;
    end else if (I_CE) begin
      for (int s = 0; s < N_SRC; s++) begin
        next_r.req_any[s] = |eff_req[s*N_CH +: N_CH];
      end
      for (int c = 0; c < NR; c++) begin
        next_r.grant[c] = avail[c / N_CH] & eff_req[c];
      end

      // Prescaler; one enable feeds every synchronous clock of the domain
      next_r.d.irq    = 1'b0;
      next_r.d.viol   = 1'b0;
      next_r.d.cpu_en = wrap;
      next_r.d.cnt    = wrap ? DIV_ZERO : r.d.cnt + DIV_ONE;
      if (wrap && r.d.pending) begin
        // Switch only on a period boundary so no clock sees a runt pulse
        next_r.d.div_act = r.d.pend;
        next_r.d.pending = 1'b0;
        next_r.d.ready   = 1'b1;
        next_r.d.irq     = I_CLOCK_READY_FLAG_INT_EN;
      end

      // An allowed write in the apply cycle wins over the ready set
      if (I_DIV_WR) begin
        next_r.d.div_reg = I_DIV_DATA;
        if (!r.d.ready) begin
          next_r.d.viol = 1'b1;
        end
        if (!ocd_div_allowed(I_DIV_DATA)) begin
          next_r.d.viol = 1'b1;
        end else begin
          next_r.d.pend    = I_DIV_DATA;
          next_r.d.pending = 1'b1;
          next_r.d.ready   = 1'b0;
          next_r.d.irq     = 1'b0;
        end
      end

      if (I_MASK_WR) begin
        next_r.mask = I_MASK_DATA;
      end
      for (int b = 0; b < N_BUS; b++) begin
        next_r.bus_clk[b] = r.mask[b] & wrap;
      end
      next_r.bus_wr = I_BUS_WR & r.mask[I_BUS_SEL];
      next_r.rdata  = r.mask[I_BUS_SEL] ? I_BUS_RDATA : '0;
    end
  end

  always_ff @(posedge I_CLK) begin
    r <= next_r;
  end

  assign O_SRC_EN                = src_en;
  assign O_SRC_AVAIL             = avail;
  assign O_CLK_GRANT             = r.grant;
  assign O_CPU_CLK_EN            = r.d.cpu_en;
  assign O_CPU_DIVISION_REGISTER = r.d.div_reg;
  assign O_CLOCK_READY_FLAG      = r.d.ready;
  assign O_CLOCK_READY_FLAG_IRQ             = r.d.irq;
  assign O_PROTECT_VIOLATION     = r.d.viol;
  assign O_BUS_CLK_EN            = r.bus_clk;
  assign O_BUS_MASK              = r.mask;
  assign O_BUS_WR                = r.bus_wr;
  assign O_BUS_RDATA             = r.rdata;

  sequence good_write_s;
    I_CE && !I_SRST && I_DIV_WR && ocd_div_allowed(I_DIV_DATA) && r.d.ready;
  endsequence

  sequence bad_write_s;
    I_CE && !I_SRST && I_DIV_WR && !ocd_div_allowed(I_DIV_DATA) && r.d.ready && !r.d.pending;
  endsequence

  sequence apply_s;
    I_CE && !I_SRST && !I_DIV_WR && r.d.pending && wrap;
  endsequence

  gen_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE && (eff_req[N_CH-1:0] == '0) |=> !r.req_any[0])
    else $error("disabled path still forwarded a request");

  standby_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE && I_STANDBY && I_RUN_IN_STANDBY[0] && I_PERIPH_REQ[0] && I_PERIPH_EN[0]
      && I_CHAN_EN[0] && I_GEN_EN[0] |=> r.req_any[0])
    else $error("standby request from run-in-standby module dropped");

  reset_undivided_a: assert property (@(posedge I_CLK)
    $past(I_SRST) && !I_SRST |-> (r.d.div_act == DIV_RESET) && r.d.ready
      && !r.mask[COMPARATOR_BUS_BIT] && !r.mask[CONVERTER0_BUS_BIT])
    else $error("reset state of prescaler or masks wrong");

  ready_drop_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    good_write_s |=> !O_CLOCK_READY_FLAG && !O_CLOCK_READY_FLAG_IRQ)
    else $error("ready flag not cleared by division write");

  bad_div_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    bad_write_s |=> O_PROTECT_VIOLATION && O_CLOCK_READY_FLAG
      && (r.d.div_act == $past(r.d.div_act)))
    else $error("forbidden division used or not reported");

  rewrite_viol_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE && I_DIV_WR && !r.d.ready |=> O_PROTECT_VIOLATION)
    else $error("rewrite while not ready not reported");

  apply_ready_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    apply_s |=> O_CLOCK_READY_FLAG && (r.d.div_act == $past(r.d.pend)) && (r.d.cnt == DIV_ZERO))
    else $error("new division not applied at period boundary");

  irq_on_apply_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    apply_s ##0 I_CLOCK_READY_FLAG_INT_EN |=> O_CLOCK_READY_FLAG_IRQ ##1 !O_CLOCK_READY_FLAG_IRQ || !I_CE)
    else $error("clock ready interrupt missing or stuck");

  period_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE && wrap && !r.d.pending && (r.d.div_act == 8'h02) |=> !wrap)
    else $error("prescaler period shorter than division");

  mask_gate_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE && !r.mask[I_BUS_SEL] |=> (O_BUS_RDATA == '0) && !O_BUS_WR)
    else $error("masked peripheral access passed");

  mask_clk_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    I_CE |=> (O_BUS_CLK_EN & ~$past(r.mask)) == '0)
    else $error("masked bus clock still running");

endmodule

// ---- verification/ocd_src_model.sv ----
`timescale 1ns/1ps
// Oscillators behind each source: ready after startup, ticks only while enabled
module ocd_src_model
  import ocd_pkg::*;
#(
  parameter int N       = N_SRC_DEF,
  parameter int STARTUP = 6,
  parameter int SRC_P   = 3,
  parameter int DIV_P   = 5
) (
  input  wire logic         i_clk,
  input  wire logic [N-1:0] i_en,
  output logic      [N-1:0] o_ready,
  output logic      [N-1:0] o_src_tick,
  output logic      [N-1:0] o_div_tick
);
  int age [N];

  // A stopped source loses ready at once and its ticks stand still
  always @(posedge i_clk) begin
    for (int i = 0; i < N; i++) begin
      age[i] = i_en[i] ? age[i] + 1 : 0;
      o_ready[i] <= age[i] > STARTUP;
      o_src_tick[i] <= age[i] > STARTUP && age[i] % SRC_P == 0;
      o_div_tick[i] <= age[i] > STARTUP && age[i] % DIV_P == 0;
    end
  end
endmodule

// ---- verification/ocd_top_bench.sv ----
`timescale 1ns/1ps
module ocd_top_bench;
  import ocd_pkg::*;
  localparam int NR = N_SRC_DEF * N_CH_DEF;
  localparam int SU = 6;
  localparam int SP = 3;
  localparam int DP = 5;

  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic [1:0]            rdy, stick, dtick, odr, gen_en, src_en, avail;
  logic [NR-1:0]         chan_en, per_en, req, ris, grant;
  logic                  stby, div_wr, int_en, mask_wr, bus_wr, ce, bce_clr;
  logic [7:0]            div_data, mask_data, div_reg, mask, bce;
  logic [7:0]            bce_seen = '0;
  logic [2:0]            bus_sel;
  logic [31:0]           rdata_in, rdata;
  logic                  cpu_en, rdy_flag, irq, viol, bwr;
  int                    viol_n = 0;
  int                    irq_n = 0;
  int                    b;
  int                    fail_count = 0;
  int                    checks_done = 0;
  int                    n;
  int                    p;
  logic [7:0]            vals [3] = '{8'h01, 8'hFF, 8'h04};

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ocd_top u_ocd_top (
    .I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_SRC_READY(rdy), .I_SRC_TICK(stick),
    .I_DIV_TICK(dtick), .I_REQUEST_DRIVEN_RUN(odr), .I_GEN_EN(gen_en), .I_CHAN_EN(chan_en),
    .I_PERIPH_EN(per_en), .I_PERIPH_REQ(req), .I_RUN_IN_STANDBY(ris), .I_STANDBY(stby),
    .I_DIV_WR(div_wr), .I_DIV_DATA(div_data), .I_CLOCK_READY_FLAG_INT_EN(int_en),
    .I_MASK_WR(mask_wr), .I_MASK_DATA(mask_data), .I_BUS_SEL(bus_sel), .I_BUS_WR(bus_wr),
    .I_BUS_RDATA(rdata_in), .O_SRC_EN(src_en), .O_SRC_AVAIL(avail), .O_CLK_GRANT(grant),
    .O_CPU_CLK_EN(cpu_en), .O_CPU_DIVISION_REGISTER(div_reg), .O_CLOCK_READY_FLAG(rdy_flag),
    .O_CLOCK_READY_FLAG_IRQ(irq), .O_PROTECT_VIOLATION(viol), .O_BUS_CLK_EN(bce), .O_BUS_MASK(mask),
    .O_BUS_WR(bwr), .O_BUS_RDATA(rdata));

  ocd_src_model #(.N(2), .STARTUP(SU), .SRC_P(SP), .DIV_P(DP)) u_ocd_src_model (
    .i_clk(clk), .i_en(src_en), .o_ready(rdy), .o_src_tick(stick), .o_div_tick(dtick));

  // Pulses are counted here so a check never races the launching edge
  always @(posedge clk) begin
    if (viol === 1'b1) viol_n <= viol_n + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    bce_seen <= bce_clr ? bce : bce_seen | bce;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic sig(input int sel, input int idx);
    case (sel)
      0: return src_en[idx];
      1: return grant[idx];
      2: return rdy_flag;
      default: return cpu_en;
    endcase
  endfunction

  task automatic wait_for(input int sel, input int idx, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (sig(sel, idx) !== lvl && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  // A wait that must end; running out of cycles ends the run
  task automatic need(input int sel, input int idx, input logic lvl, input int lim,
                      output int cnt);
    wait_for(sel, idx, lvl, lim, cnt);
    if (cnt >= lim) begin
      fail_count++;
      $display("unexpected timeout waiting on signal %0d index %0d", sel, idx);
      complete_run();
    end
  endtask

  task automatic div_write(input logic [7:0] v);
    @(negedge clk);
    div_wr = 1'b1;
    div_data = v;
    @(negedge clk);
    div_wr = 1'b0;
    chk("division register", v, div_reg);
  endtask

  // One spare cycle first, so a pulse built from the old mask is not caught
  task automatic clear_seen;
    @(negedge clk);
    bce_clr = 1'b1;
    @(negedge clk);
    bce_clr = 1'b0;
  endtask

  task automatic period(output int per);
    int c;
    need(3, 0, 1'b1, 300, c);
    @(negedge clk);
    need(3, 0, 1'b1, 300, c);
    per = c + 1;
  endtask

  task automatic try_req(input int k);
    per_en[0] = (k != 0);
    chan_en[0] = (k != 1);
    gen_en[0] = (k != 2);
    stby = (k >= 3);
    ris[0] = (k == 4);
    @(negedge clk);
    req[0] = 1'b1;
    wait_for(0, 0, 1'b1, 40, n);
    chk("qualified request", k == 4, src_en[0]);
    req[0] = 1'b0;
    per_en = '1;
    chan_en = '1;
    gen_en = '1;
    stby = 1'b0;
    ris = '0;
    need(0, 0, 1'b0, 60, n);
  endtask

  initial begin
    {odr, gen_en, chan_en, per_en} = '1;
    {req, ris, stby, div_wr, int_en, mask_wr, bus_wr, bce_clr} = '0;
    {div_data, mask_data, bus_sel} = '0;
    ce = 1'b1;
    rdata_in = 32'hA5A5_5A5A;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("source enable", 2'h0, src_en);
    chk("division register", DIV_RESET, div_reg);
    chk("ready flag", 1'b1, rdy_flag);
    chk("cpu enable", 1'b1, cpu_en);
    chk("bus mask", 8'hFC, mask);
    clear_seen();
    repeat (9) @(negedge clk);
    chk("bus clocks running", 8'hFC, bce_seen);

    // Start and stop latency on source 1
    req[4] = 1'b1;
    need(1, 4, 1'b1, 80, n);
    chk("start latency", 1'b1, n >= SU + SP + DP && n <= SU + 2 * (SP + DP) + 8);
    chk("idle source", 1'b0, src_en[0]);
    req[4] = 1'b0;
    need(0, 1, 1'b0, 80, n);
    chk("stop latency", 1'b1, n >= SP + DP && n <= 2 * (SP + DP) + 6);

    // Source stays up until its last requester drops
    req[1:0] = 2'h3;
    need(1, 0, 1'b1, 80, n);
    req[0] = 1'b0;
    repeat (30) @(negedge clk);
    chk("shared source", 2'h3, {src_en[0], grant[1]});
    req[1] = 1'b0;
    need(0, 0, 1'b0, 80, n);

    for (int k = 0; k < 5; k++) try_req(k);

    // Long enough to reach the run state with no request at all
    odr[0] = 1'b0;
    repeat (40) @(negedge clk);
    chk("always running source", 2'h3, {src_en[0], avail[0]});
    odr[0] = 1'b1;
    need(0, 0, 1'b0, 80, n);

    // Divisions taking effect, ready flag and interrupt
    for (int i = 0; i < 3; i++) begin
      int_en = (i != 0);
      b = irq_n;
      div_write(vals[i]);
      chk("ready after write", 1'b0, rdy_flag);
      need(2, 0, 1'b1, 300, n);
      @(negedge clk);
      chk("ready interrupt", int_en, irq_n - b);
      period(p);
      chk("cpu period", vals[i], p);
    end

    b = viol_n;
    div_write(8'h00);
    repeat (2) @(negedge clk);
    chk("forbidden violation", 1, viol_n - b);
    chk("ready kept", 1'b1, rdy_flag);
    period(p);
    chk("cpu period kept", 4, p);

    // Rewrite while not ready: deliberate breach of the software rule
    b = viol_n;
    @(negedge clk);
    div_wr = 1'b1;
    div_data = 8'h08;
    @(negedge clk);
    div_data = 8'h02;
    @(negedge clk);
    div_wr = 1'b0;
    chk("division register", 8'h02, div_reg);
    need(2, 0, 1'b1, 300, n);
    chk("rewrite violation", 1, viol_n - b);
    period(p);
    chk("cpu period", 2, p);

    // Masks and bus pass-through
    @(negedge clk);
    mask_wr = 1'b1;
    mask_data = 8'hF7;
    @(negedge clk);
    mask_wr = 1'b0;
    chk("bus mask", 8'hF7, mask);
    clear_seen();
    bus_sel = 3'h3;
    bus_wr = 1'b1;
    @(negedge clk);
    chk("masked write", 1'b0, bwr);
    chk("masked read", 32'h0, rdata);
    bus_sel = 3'h4;
    @(negedge clk);
    chk("open write", 1'b1, bwr);
    chk("open read", 32'hA5A5_5A5A, rdata);
    bus_wr = 1'b0;
    repeat (8) @(negedge clk);
    chk("bus clocks running", 8'hF7, bce_seen);

    // Clock enable low: a mask write and the prescaler both hold still
    ce = 1'b0;
    mask_wr = 1'b1;
    mask_data = 8'h0F;
    @(negedge clk);
    mask_wr = 1'b0;
    b = cpu_en;
    repeat (3) @(negedge clk);
    chk("frozen mask", 8'hF7, mask);
    chk("frozen cpu enable", b, cpu_en);
    ce = 1'b1;
    @(negedge clk);
    complete_run();
  end
endmodule
